// ===== hbc_pkg.sv
// Constants, types and decoding helpers for the banked half-bridge timing registers.
package hbc_pkg;

  // Register addresses (seven-bit word addresses).
  localparam logic [6:0] ADDR_INIT = 7'h1a;
  localparam logic [6:0] ADDR_TON  = 7'h1b;
  localparam logic [6:0] ADDR_TOFF = 7'h1c;

  // Field layout.
  localparam int CODE_W    = 6;
  localparam int BANK_W    = 3;
  localparam int NUM_HB    = 4;
  localparam int DCHG_LSB  = 10;
  localparam int CHG_LSB   = 4;
  localparam int DLY_LSB   = 8;
  localparam int BANK_LSB  = 0;
  localparam int CYCLES_W  = 8;

  // Reset values.
  localparam logic [15:0]       INIT_RESET     = 16'h3cd0;
  localparam logic [15:0]       DLY_RESET      = 16'h0c00;
  localparam logic [CODE_W-1:0] DCHG_RESET     = 6'h0f;
  localparam logic [CODE_W-1:0] CHG_RESET      = 6'h0d;
  localparam logic [CODE_W-1:0] DLY_CODE_RESET = 6'h0c;
  localparam logic [BANK_W-1:0] BANK_RESET     = 3'h0;

  // Timing: one delay step and the clock period, in picoseconds.
  localparam int DELAY_STEP_PS = 53300;
  localparam int CLK_PERIOD_PS = 25000;

  typedef enum {REG_NONE, REG_INIT, REG_TON, REG_TOFF} hbc_reg_t;

  function automatic hbc_reg_t hbc_decode(input logic [6:0] addr);
    if (addr == ADDR_INIT) begin
      return REG_INIT;
    end else if (addr == ADDR_TON) begin
      return REG_TON;
    end else if (addr == ADDR_TOFF) begin
      return REG_TOFF;
    end else begin
      return REG_NONE;
    end
  endfunction : hbc_decode

  // Codes 1xx are not a half-bridge.
  function automatic logic hbc_bank_ok(input logic [BANK_W-1:0] bank);
    return ~bank[BANK_W-1];
  endfunction : hbc_bank_ok

  // Nominal delay rounded up to whole clock cycles.
  function automatic logic [CYCLES_W-1:0] hbc_cycles(input logic [CODE_W-1:0] code);
    int unsigned t;
    t = (int'(code) * DELAY_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return t[CYCLES_W-1:0];
  endfunction : hbc_cycles

endpackage : hbc_pkg

// ===== hbc_bank_store.sv
// Per-half-bridge storage of one six-bit banked code.
`timescale 1ns/1ps
module hbc_bank_store #(
  parameter int               W     = 6,
  parameter int               N     = 4,
  parameter logic [W-1:0]     RESET = '0
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire logic                 clk_en,
  input  wire logic                 soft_rst,
  // Write port
  input  wire logic                 wr_en,
  input  wire logic [$clog2(N)-1:0] wr_idx,
  input  wire logic [W-1:0]         wr_data,
  // Stored codes
  output logic      [N-1:0][W-1:0]  value
);

  logic [N-1:0][W-1:0] next_value;

  for (genvar i = 0; i < N; i++) begin : g_entry
    always_comb begin
      next_value[i] = value[i];
      if (soft_rst) begin
        next_value[i] = RESET;
      end else if (wr_en && int'(wr_idx) == i) begin
        next_value[i] = wr_data;
      end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        value[i] <= RESET;
      end else if (clk_en) begin
        value[i] <= next_value[i];
      end
    end
  end

endmodule : hbc_bank_store

// ===== hbc_bank_sel.sv
// Bank-select field of one register, cleared by soft reset and restart.
`timescale 1ns/1ps
module hbc_bank_sel
  import hbc_pkg::*;
(
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  input  wire logic                      clk_en,
  input  wire logic                      soft_rst,
  input  wire logic                      restart,
  // Write port
  input  wire logic                      wr_en,
  input  wire logic [hbc_pkg::BANK_W-1:0] wr_bank,
  // Held selection
  output logic      [hbc_pkg::BANK_W-1:0] bank
);

  logic [BANK_W-1:0] next_bank;

  always_comb begin
    next_bank = bank;
    if (soft_rst || restart) begin
      next_bank = BANK_RESET;
    end else if (wr_en) begin
      next_bank = wr_bank;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bank <= BANK_RESET;
    end else if (clk_en) begin
      bank <= next_bank;
    end
  end

endmodule : hbc_bank_sel

// ===== hbc_timing_regs.sv
// Banked pre-charge current and turn-on/turn-off delay registers for four half-bridges.
`timescale 1ns/1ps

// Notes on behaviour
// - Discharge code bits 15:10, default 001111.
// - Charge code bits 9:4, default 001101.
// - Init bank 2:0 picks bridge; 1xx invalid.
// - Separate codes per bridge, accessed through bank.
// - Init bit 3 always reads zero.
// - Soft reset loads init register 0x3cd0.
// - Restart clears init bank, keeps codes.
// - Turn-on code 13:8, 53.3 ns per step.
// - Turn-on bank 2:0 picks bridge; 1xx invalid.
// - Turn-off code 13:8, 53.3 ns per step.
// - Turn-off bank 2:0 picks bridge; 1xx invalid.
// - Delay bits 15:14 and 7:3 read zero.
// - Soft reset loads delay registers 0x0c00.
// - Restart clears delay banks, keeps codes.
// - Access comes as frame word with address.
module hbc_timing_regs
  import hbc_pkg::*;
(
  // Clock and reset
  input  wire logic                                               sys_clk,
  input  wire logic                                               rst_b,
  input  wire logic                                               clk_en,
  // Device-level resets
  input  wire logic                                               soft_rst,
  input  wire logic                                               restart,
  // Register access from the frame decoder
  input  wire logic                                               reg_wr,
  input  wire logic                                               reg_rd,
  input  wire logic [6:0]                                         reg_addr,
  input  wire logic [15:0]                                        reg_wdata,
  output logic      [15:0]                                        reg_rdata,
  output logic                                                    reg_rvalid,
  // Per-bridge settings to the gate drivers
  output logic      [hbc_pkg::NUM_HB-1:0][hbc_pkg::CODE_W-1:0]    discharge_code,
  output logic      [hbc_pkg::NUM_HB-1:0][hbc_pkg::CODE_W-1:0]    charge_code,
  output logic      [hbc_pkg::NUM_HB-1:0][hbc_pkg::CODE_W-1:0]    turn_on_delay_code,
  output logic      [hbc_pkg::NUM_HB-1:0][hbc_pkg::CODE_W-1:0]    turn_off_delay_code,
  output logic      [hbc_pkg::NUM_HB-1:0][hbc_pkg::CYCLES_W-1:0]  turn_on_cycles,
  output logic      [hbc_pkg::NUM_HB-1:0][hbc_pkg::CYCLES_W-1:0]  turn_off_cycles
);

  localparam int IDX_W = $clog2(NUM_HB);

  hbc_reg_t           wr_sel;
  hbc_reg_t           rd_sel;
  logic [BANK_W-1:0]  wr_bank;
  logic [IDX_W-1:0]   wr_idx;
  logic               wr_ok;
  logic               init_wr;
  logic               ton_wr;
  logic               toff_wr;
  logic [BANK_W-1:0]  init_bridge_select;
  logic [BANK_W-1:0]  turn_on_bridge_select;
  logic [BANK_W-1:0]  turn_off_bridge_select;
  logic [15:0]        next_rdata;
  logic               next_rvalid;
  hbc_reg_t           rd_kind;
  hbc_reg_t           next_rd_kind;

  logic [NUM_HB-1:0][CYCLES_W-1:0] next_on_cycles;
  logic [NUM_HB-1:0][CYCLES_W-1:0] next_off_cycles;

  // The frame decoder hands over one whole word per access.
  assign wr_sel  = hbc_decode(reg_addr);
  assign rd_sel  = hbc_decode(reg_addr);
  assign wr_bank = reg_wdata[BANK_LSB +: BANK_W];
  assign wr_idx  = wr_bank[IDX_W-1:0];
  // The bank written with the word also steers its value fields.
  assign wr_ok   = hbc_bank_ok(wr_bank);

  // A restart in the same cycle as a write wins, so the codes stay as they were.
  assign init_wr = reg_wr && wr_sel == REG_INIT && !restart;
  assign ton_wr  = reg_wr && wr_sel == REG_TON && !restart;
  assign toff_wr = reg_wr && wr_sel == REG_TOFF && !restart;

  // Bank fields.
  hbc_bank_sel u_init_bank (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .soft_rst (soft_rst),
    .restart  (restart),
    .wr_en    (init_wr),
    .wr_bank  (wr_bank),
    .bank     (init_bridge_select)
  );

  hbc_bank_sel u_ton_bank (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .soft_rst (soft_rst),
    .restart  (restart),
    .wr_en    (ton_wr),
    .wr_bank  (wr_bank),
    .bank     (turn_on_bridge_select)
  );

  hbc_bank_sel u_toff_bank (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .soft_rst (soft_rst),
    .restart  (restart),
    .wr_en    (toff_wr),
    .wr_bank  (wr_bank),
    .bank     (turn_off_bridge_select)
  );

  // Value stores, one entry per half-bridge.
  hbc_bank_store #(.W(CODE_W), .N(NUM_HB), .RESET(DCHG_RESET)) u_dchg (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .soft_rst (soft_rst),
    .wr_en    (init_wr && wr_ok),
    .wr_idx   (wr_idx),
    .wr_data  (reg_wdata[DCHG_LSB +: CODE_W]),
    .value    (discharge_code)
  );

  hbc_bank_store #(.W(CODE_W), .N(NUM_HB), .RESET(CHG_RESET)) u_chg (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .soft_rst (soft_rst),
    .wr_en    (init_wr && wr_ok),
    .wr_idx   (wr_idx),
    .wr_data  (reg_wdata[CHG_LSB +: CODE_W]),
    .value    (charge_code)
  );

  hbc_bank_store #(.W(CODE_W), .N(NUM_HB), .RESET(DLY_CODE_RESET)) u_ton (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .soft_rst (soft_rst),
    .wr_en    (ton_wr && wr_ok),
    .wr_idx   (wr_idx),
    .wr_data  (reg_wdata[DLY_LSB +: CODE_W]),
    .value    (turn_on_delay_code)
  );

  hbc_bank_store #(.W(CODE_W), .N(NUM_HB), .RESET(DLY_CODE_RESET)) u_toff (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .soft_rst (soft_rst),
    .wr_en    (toff_wr && wr_ok),
    .wr_idx   (wr_idx),
    .wr_data  (reg_wdata[DLY_LSB +: CODE_W]),
    .value    (turn_off_delay_code)
  );

  // Read path; an invalid bank shows its own bits and zero value fields.
  always_comb begin
    next_rdata   = reg_rdata;
    next_rvalid  = 1'b0;
    next_rd_kind = rd_kind;
    if (reg_rd) begin
      next_rvalid  = 1'b1;
      next_rd_kind = rd_sel;
      next_rdata   = 16'h0000;
      case (rd_sel)
        REG_INIT: begin
          next_rdata[BANK_LSB +: BANK_W] = init_bridge_select;
          if (hbc_bank_ok(init_bridge_select)) begin
            next_rdata[DCHG_LSB +: CODE_W] = discharge_code[init_bridge_select[IDX_W-1:0]];
            next_rdata[CHG_LSB +: CODE_W]  = charge_code[init_bridge_select[IDX_W-1:0]];
          end
        end
        REG_TON: begin
          next_rdata[BANK_LSB +: BANK_W] = turn_on_bridge_select;
          if (hbc_bank_ok(turn_on_bridge_select)) begin
            next_rdata[DLY_LSB +: CODE_W] = turn_on_delay_code[turn_on_bridge_select[IDX_W-1:0]];
          end
        end
        REG_TOFF: begin
          next_rdata[BANK_LSB +: BANK_W] = turn_off_bridge_select;
          if (hbc_bank_ok(turn_off_bridge_select)) begin
            next_rdata[DLY_LSB +: CODE_W] = turn_off_delay_code[turn_off_bridge_select[IDX_W-1:0]];
          end
        end
        default: begin
          next_rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
      rd_kind    <= REG_NONE;
    end else if (clk_en) begin
      reg_rdata  <= next_rdata;
      reg_rvalid <= next_rvalid;
      rd_kind    <= next_rd_kind;
    end
  end

  // Delay codes as clock cycles; registered, so they trail a code change by one cycle.
  for (genvar i = 0; i < NUM_HB; i++) begin : g_cycles
    always_comb begin
      next_on_cycles[i]  = hbc_cycles(turn_on_delay_code[i]);
      next_off_cycles[i] = hbc_cycles(turn_off_delay_code[i]);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      turn_on_cycles  <= '0;
      turn_off_cycles <= '0;
    end else if (clk_en) begin
      turn_on_cycles  <= next_on_cycles;
      turn_off_cycles <= next_off_cycles;
    end
  end

  // Checks.
  sequence init_write_s;
    clk_en && reg_wr && wr_sel == REG_INIT && !restart && !soft_rst;
  endsequence

  sequence delay_write_s;
    clk_en && reg_wr && (wr_sel == REG_TON || wr_sel == REG_TOFF) && !restart && !soft_rst;
  endsequence

  sequence soft_reset_s;
    clk_en && soft_rst;
  endsequence

  init_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    soft_reset_s |=> init_bridge_select == BANK_RESET
      && discharge_code[0] == INIT_RESET[DCHG_LSB +: CODE_W]
      && charge_code[0] == INIT_RESET[CHG_LSB +: CODE_W])
    else $error("Soft reset did not restore the initialisation register.");

  delay_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    soft_reset_s |=> turn_on_delay_code[0] == DLY_RESET[DLY_LSB +: CODE_W]
      && turn_off_delay_code[0] == DLY_RESET[DLY_LSB +: CODE_W]
      && turn_on_bridge_select == BANK_RESET && turn_off_bridge_select == BANK_RESET)
    else $error("Soft reset did not restore the delay registers.");

  restart_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && restart && !soft_rst |=> init_bridge_select == 3'h0
      && $stable(discharge_code) && $stable(charge_code))
    else $error("Restart did not clear the bank or altered the current codes.");

  restart_delay_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && restart && !soft_rst |=> turn_on_bridge_select == 3'h0
      && turn_off_bridge_select == 3'h0
      && $stable(turn_on_delay_code) && $stable(turn_off_delay_code))
    else $error("Restart did not clear the delay banks or altered the delay codes.");

  init_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    init_write_s ##0 wr_ok |=> discharge_code[$past(wr_idx)] == $past(reg_wdata[15:10])
      && charge_code[$past(wr_idx)] == $past(reg_wdata[9:4]))
    else $error("Current codes not written to the selected half-bridge.");

  invalid_bank_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (init_write_s or delay_write_s) ##0 !wr_ok |=> $stable(discharge_code)
      && $stable(charge_code) && $stable(turn_on_delay_code) && $stable(turn_off_delay_code))
    else $error("Write with an invalid bank changed stored codes.");

  ton_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    delay_write_s ##0 wr_ok && wr_sel == REG_TON
      |=> turn_on_delay_code[$past(wr_idx)] == $past(reg_wdata[13:8])
        && turn_on_bridge_select == $past(wr_bank))
    else $error("Turn-on delay code not written to the selected half-bridge.");

  toff_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    delay_write_s ##0 wr_ok && wr_sel == REG_TOFF
      |=> turn_off_delay_code[$past(wr_idx)] == $past(reg_wdata[13:8])
        && turn_off_bridge_select == $past(wr_bank))
    else $error("Turn-off delay code not written to the selected half-bridge.");

  reserved_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reg_rvalid |-> (rd_kind != REG_INIT || reg_rdata[3] == 1'b0)
      && (rd_kind == REG_INIT || (reg_rdata[15:14] == 2'b00 && reg_rdata[7:3] == 5'h00)))
    else $error("Reserved bits read back as non-zero.");

  read_timing_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && reg_rd |=> reg_rvalid)
    else $error("Read answer missing.");

  rvalid_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && reg_rvalid && !reg_rd |=> !reg_rvalid)
    else $error("Read answer held too long.");

  // The count trails the code by one enabled edge, so it is checked against the code of the cycle before.
  cycles_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en |=> turn_off_cycles[0]
      == CYCLES_W'((int'($past(turn_off_delay_code[0])) * DELAY_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS))
    else $error("Turn-off cycle count does not match the delay code.");

  freeze_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !clk_en |=> $stable(discharge_code) && $stable(charge_code) && $stable(turn_on_delay_code)
      && $stable(turn_off_delay_code) && $stable(reg_rvalid) && $stable(reg_rdata))
    else $error("State moved while the clock enable was low.");

endmodule : hbc_timing_regs

// ===== hbc_host_model.sv
// Register-port master model standing in for the frame decoder side.
`timescale 1ns/1ps
module hbc_host_model
  import hbc_pkg::*;
(
  // Clock
  input  wire logic        sys_clk,
  // Register access
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [6:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 16'h0000;
  end

  // Released strobes drop to zero; address and data show the inverse of the last value, so nothing can lean on stale data.
  task automatic release_bus();
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : release_bus

  // One sixteen-bit word to one seven-bit address per access.
  task automatic wr(input logic [6:0] addr, input logic [15:0] data, input int gap);
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = addr;
    reg_wdata = data;
    @(posedge sys_clk);
    #1;
    release_bus();
    repeat (gap) @(posedge sys_clk);
  endtask : wr

  // The answer is taken 1 ns after the edge that samples the strobe.
  task automatic rd(input logic [6:0] addr, output logic [15:0] data, output logic valid, input int gap);
    @(posedge sys_clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = addr;
    @(posedge sys_clk);
    #1;
    release_bus();
    data  = reg_rdata;
    valid = reg_rvalid;
    repeat (gap) @(posedge sys_clk);
  endtask : rd
endmodule : hbc_host_model

// ===== tb_hbc_timing_regs.sv
// Self-checking bench for the banked half-bridge timing registers.
`timescale 1ns/1ps
module tb_hbc_timing_regs;
  import hbc_pkg::*;
  logic                             sys_clk = 1'b0;
  logic                             rst_b;
  logic                             clk_en;
  logic                             soft_rst;
  logic                             restart;
  logic                             reg_wr;
  logic                             reg_rd;
  logic [6:0]                       reg_addr;
  logic [15:0]                      reg_wdata;
  logic [15:0]                      reg_rdata;
  logic                             reg_rvalid;
  logic [NUM_HB-1:0][CODE_W-1:0]    dchg;
  logic [NUM_HB-1:0][CODE_W-1:0]    chg;
  logic [NUM_HB-1:0][CODE_W-1:0]    ton;
  logic [NUM_HB-1:0][CODE_W-1:0]    toff;
  logic [NUM_HB-1:0][CYCLES_W-1:0]  ton_cyc;
  logic [NUM_HB-1:0][CYCLES_W-1:0]  toff_cyc;
  int                               num_errors = 0;
  int                               comparisons = 0;
  int                               cycles = 0;

  always #12.5 sys_clk = ~sys_clk;

  hbc_host_model host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
                       .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  hbc_timing_regs DUT (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .soft_rst(soft_rst),
                       .restart(restart), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
                       .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
                       .discharge_code(dchg), .charge_code(chg), .turn_on_delay_code(ton),
                       .turn_off_delay_code(toff), .turn_on_cycles(ton_cyc), .turn_off_cycles(toff_cyc));

  // Test codes per bridge; the delay codes reach both ends of the six-bit range.
  function automatic logic [5:0] cd(input int i);
    return 6'(i * 9 + 3);
  endfunction : cd
  function automatic logic [5:0] cc(input int i);
    return 6'(i * 7 + 33);
  endfunction : cc
  function automatic logic [5:0] con(input int i);
    return 6'(i * 21);
  endfunction : con
  function automatic logic [5:0] cof(input int i);
    return 6'(63 - i * 11);
  endfunction : cof
  // Nominal delay of 53.3 ns per step, rounded up to 25 ns cycles.
  function automatic logic [15:0] cyc(input logic [5:0] code);
    return 16'((int'(code) * 533 + 249) / 250);
  endfunction : cyc

  task automatic summarize();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rchk(input logic [6:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    host.rd(addr, d, v, 0);
    check(16'(v), 16'h0001);
    check(d, exp);
  endtask : rchk

  task automatic bridge_chk(input int i, input logic [5:0] d, input logic [5:0] c,
                            input logic [5:0] n, input logic [5:0] f);
    check(16'(dchg[i]), 16'(d));
    check(16'(chg[i]), 16'(c));
    check(16'(ton[i]), 16'(n));
    check(16'(toff[i]), 16'(f));
    check(16'(ton_cyc[i]), cyc(n));
    check(16'(toff_cyc[i]), cyc(f));
  endtask : bridge_chk

  task automatic reset_chk();
    rchk(ADDR_INIT, 16'h3cd0);
    rchk(ADDR_TON, 16'h0c00);
    rchk(ADDR_TOFF, 16'h0c00);
    rchk(7'h1d, 16'h0000);
    for (int i = 0; i < NUM_HB; i++) begin
      bridge_chk(i, 6'h0f, 6'h0d, 6'h0c, 6'h0c);
    end
  endtask : reset_chk

  task automatic pulse(input int which);
    @(posedge sys_clk);
    #1;
    if (which == 0) begin
      restart = 1'b1;
    end else begin
      soft_rst = 1'b1;
    end
    @(posedge sys_clk);
    #1;
    restart  = 1'b0;
    soft_rst = 1'b0;
  endtask : pulse

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    rst_b    = 1'b0;
    clk_en   = 1'b1;
    soft_rst = 1'b0;
    restart  = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    reset_chk();
    // Every bridge in turn, reserved bits written as ones; some accesses slow, some back to back.
    for (int i = 0; i < NUM_HB; i++) begin
      host.wr(ADDR_INIT, {cd(i), cc(i), 1'b1, 3'(i)}, i);
      host.wr(ADDR_TON, {2'b11, con(i), 5'h1f, 3'(i)}, 0);
      host.wr(ADDR_TOFF, {2'b11, cof(i), 5'h1f, 3'(i)}, 0);
      rchk(ADDR_INIT, {cd(i), cc(i), 1'b0, 3'(i)});
      rchk(ADDR_TON, {2'b00, con(i), 5'h00, 3'(i)});
      rchk(ADDR_TOFF, {2'b00, cof(i), 5'h00, 3'(i)});
    end
    for (int i = 0; i < NUM_HB; i++) begin
      bridge_chk(i, cd(i), cc(i), con(i), cof(i));
    end
    // An invalid bank must not reach any bridge's stored codes.
    host.wr(ADDR_INIT, {6'h3e, 6'h3e, 1'b0, 3'b100}, 0);
    host.wr(ADDR_TON, {2'b00, 6'h3e, 5'h00, 3'b111}, 0);
    host.wr(ADDR_TOFF, {2'b00, 6'h3e, 5'h00, 3'b101}, 0);
    rchk(ADDR_INIT, 16'h0004);
    rchk(ADDR_TON, 16'h0007);
    rchk(ADDR_TOFF, 16'h0005);
    for (int i = 0; i < NUM_HB; i++) begin
      bridge_chk(i, cd(i), cc(i), con(i), cof(i));
    end
    // A write offered while the clock enable is low must leave bank and codes alone.
    clk_en = 1'b0;
    host.wr(ADDR_TOFF, {2'b00, 6'h01, 5'h00, 3'd1}, 0);
    clk_en = 1'b1;
    rchk(ADDR_TOFF, 16'h0005);
    // Restart from a non-zero bank: banks fall back to bridge zero, codes stay.
    host.wr(ADDR_INIT, {cd(2), cc(2), 1'b0, 3'd2}, 0);
    pulse(0);
    rchk(ADDR_INIT, {cd(0), cc(0), 4'h0});
    rchk(ADDR_TON, {2'b00, con(0), 8'h00});
    rchk(ADDR_TOFF, {2'b00, cof(0), 8'h00});
    for (int i = 0; i < NUM_HB; i++) begin
      bridge_chk(i, cd(i), cc(i), con(i), cof(i));
    end
    // Soft reset brings back every reset value.
    pulse(1);
    reset_chk();
    summarize();
  end
endmodule : tb_hbc_timing_regs
